// ---- adp_datapath.sv ----
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Data words are 48 bits: 8 guard bits on top, 16 precision bits below.
// - Samples sit under the guard field, bit 39 is their sign.
// - Words are signed fixed point, 25 integer and 23 fraction bits.
// - Multiply takes a 48-bit word and 28-bit coefficient, one cycle, 76-bit product.
// - Accumulate adds each 76-bit product into a 76-bit running sum.
// - The 76-bit adder never saturates; overflow wraps.
// - Samples enter as 24-bit words right after the frame sync pulse.
// - Results leave on four 32-bit two's complement buses.
// - Two reads and one write per store per cycle; 48-bit data and 28-bit coefficient stores.
// - The instruction-side shift register also serves as a random source.
// - Memories, seed, program counter and pointers share one address space.
// - 24 delay pointers: eight move 48-bit words in two locations, 16 move 24-bit.
// - Delay store is 17408 x 24, single port, access under four clocks.
// - The clear pin zeroes every delay location; all logic on the DSP clock.
// - Regions are contiguous, so only each region's end is programmed.
// - Starts derive from previous ends: first zero, then plus one, plus two after a full region.
// - A delay write holds data, select and low strobe at least four clocks.
// - The selected pointer advances only after the write and strobe release.
// - Read data is valid four clocks after the select is driven.
// - The 55-bit instruction holds five operations plus a top extension bit.
// - Bit 54 widens each direct internal memory address by one bit, 1K to 2K; pointer addresses ignore it.
// - The extension bit adds 1K to the direct instruction addresses; pointer addresses ignore it.
module adp_datapath #(
    parameter int CLEAR_WORDS = adp_pkg::DLY_WORDS // Delay words swept by a clear
) (
    input  wire logic               clk_sys,            // DSP clock
    input  wire logic               rst,                // Asynchronous reset
    input  wire logic [12:0]        regAddr,            // Register word address
    input  wire logic [47:0]        regWdata,           // Register write data
    input  wire logic               regWr,              // Register write strobe
    input  wire logic               regRd,              // Register read strobe
    output logic      [47:0]        regRdata,           // Read data, cycle after strobe
    input  wire logic [54:0]        instrWord,          // Current instruction
    input  wire logic               instrValid,         // Instruction executes this cycle
    input  wire logic [23:0]        sampleIn,           // Sample from serial audio port
    input  wire logic               frameSync,          // Frame sync pulse
    output logic      [3:0][31:0]   outBus,             // Four result buses
    input  wire logic [4:0]         delaySelect,        // Delay pointer select
    input  wire logic [47:0]        delayWriteBus,      // Delay write data
    input  wire logic               delayWriteStrobe_n, // Delay write strobe, low active
    output logic      [47:0]        delayReadBus,       // Delay read data
    input  wire logic               memClear,           // Delay clear pin
    output logic                    clearBusy,          // Clear sweep running
    output logic      [14:0]        dlyAddr,            // Delay RAM address
    output logic      [23:0]        dlyWdata,           // Delay RAM write data
    output logic                    dlyWe,              // Delay RAM write enable
    output logic                    dlyRd,              // Delay RAM read enable
    input  wire logic [23:0]        dlyRdata            // Delay RAM data, one cycle late
);
    // Instruction fields
    wire logic        ext  = instrWord[adp_pkg::EXT_BIT];
    wire logic [4:0]  p1Op = instrWord[adp_pkg::P1_LSB +: 5];
    wire logic [6:0]  p2Op = instrWord[adp_pkg::P2_LSB +: 7];
    wire logic [4:0]  mop1 = instrWord[adp_pkg::M1_LSB +: 5];
    wire logic [9:0]  ad1  = instrWord[adp_pkg::A1_LSB +: 10];
    wire logic [2:0]  mop2 = instrWord[adp_pkg::M2_LSB +: 3];
    wire logic [9:0]  ad2  = instrWord[adp_pkg::A2_LSB +: 10];
    wire logic [3:0]  mop3 = instrWord[adp_pkg::M3_LSB +: 4];
    wire logic [9:0]  ad3  = instrWord[adp_pkg::A3_LSB +: 10];

    logic [47:0] dataMem [adp_pkg::MEM_WORDS];
    logic [27:0] coefMem [adp_pkg::MEM_WORDS];
    logic [10:0] memPtr  [4];
    logic [47:0] sampleWord;
    logic [31:0] pseudo_random_shift_register;
    logic [31:0] seed;
    logic [11:0] pc;

    // Extension bit prefixes each direct address, an offset of 1K words
    wire logic [10:0] dAddr = mop1[0] ? memPtr[{1'b0, mop1[1]}] : {ext, ad1};
    wire logic [10:0] cAddr = mop2[0] ? memPtr[{1'b1, mop2[1]}] : {ext, ad2};
    wire logic [10:0] sAddr = {ext, ad3};

    // Two reads per cycle from separate stores
    wire logic [47:0] dataRd = dataMem[dAddr];
    wire logic [27:0] coefRd = coefMem[cAddr];
    wire logic [47:0] randWord = {{16{pseudo_random_shift_register[31]}}, pseudo_random_shift_register};
    wire logic [47:0] operand =
        (p2Op[1:0] == adp_pkg::SRC_SAMPLE) ? sampleWord :
        (p2Op[1:0] == adp_pkg::SRC_RAND)   ? randWord : dataRd;

    adp_mac_if macIf ();
    assign macIf.operand = operand;
    assign macIf.coef    = coefRd;
    assign macIf.op      = instrValid ? adp_pkg::adp_macop_e'(p1Op[1:0]) : adp_pkg::MAC_NOP;

    adp_mac_unit uMac (
        .clk_sys (clk_sys),
        .rst     (rst),
        .mac     (macIf.unit)
    );

    // 25.23 view of the accumulator
    wire logic [47:0] result = macIf.acc[adp_pkg::RES_LSB +: 48];

    // Register decode
    wire logic selCoef = regAddr < adp_pkg::DATA_BASE;
    wire logic selData = !selCoef && regAddr < adp_pkg::MISC_BASE;
    wire logic selSeed = regAddr == adp_pkg::SEED_ADDR;
    wire logic selPc   = regAddr == adp_pkg::PC_ADDR;
    wire logic selPtr  = regAddr >= adp_pkg::PTR_BASE && regAddr < adp_pkg::STAT_ADDR;
    wire logic selStat = regAddr == adp_pkg::STAT_ADDR;
    wire logic selEnd  = regAddr >= adp_pkg::END_BASE
                         && regAddr < adp_pkg::END_BASE + 13'(adp_pkg::NUM_PTRS);
    wire logic [1:0] ptrIdx = 2'(regAddr - adp_pkg::PTR_BASE);
    wire logic [4:0] endIdx = 5'(regAddr - adp_pkg::END_BASE);
    wire logic [10:0] memIdx = regAddr[10:0];

    // One store per memory per cycle; a register write wins over the instruction store
    wire logic stData = instrValid && mop3[0];
    wire logic stCoef = instrValid && mop3[1];
    wire logic [3:0] incPtr = {4{instrValid}} & {
        mop2[0] & mop2[2] & mop2[1], mop2[0] & mop2[2] & ~mop2[1],
        mop1[0] & mop1[2] & mop1[1], mop1[0] & mop1[2] & ~mop1[1]};

    always_ff @(posedge clk_sys) begin
        if (regWr && selData) begin
            dataMem[memIdx] <= regWdata;
        end else if (stData) begin
            dataMem[sAddr] <= result;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (regWr && selCoef) begin
            coefMem[memIdx] <= regWdata[27:0];
        end else if (stCoef) begin
            coefMem[sAddr] <= result[27:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) memPtr[i] <= 11'h000;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (regWr && selPtr && ptrIdx == 2'(i)) begin
                    memPtr[i] <= regWdata[10:0];
                end else if (incPtr[i]) begin
                    memPtr[i] <= memPtr[i] + 11'h001;
                end
            end
        end
    end

    // Random source runs every cycle; a seed write restarts it
    wire logic [31:0] next_pseudo_random_shift_register = {pseudo_random_shift_register[30:0], pseudo_random_shift_register[31] ^ pseudo_random_shift_register[21] ^ pseudo_random_shift_register[1] ^ pseudo_random_shift_register[0]};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            seed <= adp_pkg::SEED_RST;
            pseudo_random_shift_register <= adp_pkg::SEED_RST;
            pc   <= 12'h000;
        end else begin
            if (regWr && selSeed) begin
                seed <= regWdata[31:0];
                pseudo_random_shift_register <= regWdata[31:0];
            end else begin
                pseudo_random_shift_register <= next_pseudo_random_shift_register;
            end
            if (regWr && selPc) begin
                pc <= regWdata[11:0];
            end else if (instrValid) begin
                pc <= pc + 12'h001;
            end
        end
    end

    // Sample lands under the guard bits, sign extended into them, noise bits zero
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sampleWord <= 48'h0;
        end else if (frameSync) begin
            sampleWord <= {{adp_pkg::GUARD{sampleIn[23]}}, sampleIn,
                           {adp_pkg::NOISE{1'b0}}};
        end
    end

    // Output buses keep the top 32 bits; the noise bits are dropped
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            outBus <= '0;
        end else if (instrValid && p2Op[2]) begin
            outBus[p2Op[4:3]] <= result[47:adp_pkg::OUT_LSB];
        end
    end

    // Delay memory interface
    logic [14:0] endAddr   [adp_pkg::NUM_PTRS];
    logic [14:0] ptrOff    [adp_pkg::NUM_PTRS];
    logic [14:0] startAddr [adp_pkg::NUM_PTRS];
    logic [1:0]  clrSync;
    logic        clrLast;
    logic        clearing;
    logic [14:0] clrAddr;
    logic [2:0]  wrPh;
    logic [2:0]  rdPh;
    logic [4:0]  selPrev;
    logic [23:0] rdLo;

    // Only ends are stored; each start follows from the region before it
    always_comb begin
        startAddr[0] = 15'h0000;
        for (int i = 1; i < adp_pkg::NUM_PTRS; i++) begin
            startAddr[i] = endAddr[i-1]
                + ((i > adp_pkg::SHORT_PTRS) ? 15'h0002 : 15'h0001);
        end
    end

    wire logic        selOk    = delaySelect < 5'(adp_pkg::NUM_PTRS);
    wire logic [4:0]  selIdx   = selOk ? delaySelect : 5'h00;
    wire logic        full     = selIdx >= 5'(adp_pkg::SHORT_PTRS);
    wire logic [14:0] step     = full ? 15'h0002 : 15'h0001;
    wire logic [14:0] curAddr  = startAddr[selIdx] + ptrOff[selIdx];
    wire logic        atEnd    = curAddr >= endAddr[selIdx];
    wire logic [14:0] nextOff  = atEnd ? 15'h0000 : ptrOff[selIdx] + step;
    wire logic [14:0] nextAddr = startAddr[selIdx] + nextOff;
    wire logic        wrActive = !delayWriteStrobe_n && selOk && !clearing;
    // A phase count still at its limit with the strobe high means it was just released
    wire logic advance  = wrPh == adp_pkg::ACCESS_CLKS && delayWriteStrobe_n;
    wire logic rdStart  = (delaySelect != selPrev) || advance;
    wire logic clrStart = clrSync[1] && !clrLast;
    wire logic clrEnd   = clrAddr == 15'(CLEAR_WORDS - 1);

    // Single RAM port: clear, then write, then read
    logic [14:0] next_dlyAddr;
    logic [23:0] next_dlyWdata;
    logic        next_dlyWe;
    logic        next_dlyRd;

    always_comb begin
        next_dlyAddr  = dlyAddr;
        next_dlyWdata = 24'h0;
        next_dlyWe    = 1'b0;
        next_dlyRd    = 1'b0;
        if (clearing) begin
            next_dlyAddr = clrAddr;
            next_dlyWe   = 1'b1;
        end else if (wrActive && wrPh == 3'h0) begin
            next_dlyAddr  = curAddr;
            next_dlyWdata = delayWriteBus[23:0];
            next_dlyWe    = 1'b1;
        end else if (wrActive && wrPh == 3'h1 && full) begin
            next_dlyAddr  = curAddr + 15'h0001;
            next_dlyWdata = delayWriteBus[47:24];
            next_dlyWe    = 1'b1;
        end else if (rdStart && selOk && !wrActive) begin
            next_dlyAddr = advance ? nextAddr : curAddr;
            next_dlyRd   = 1'b1;
        end else if (rdPh == 3'h1 && full && !wrActive) begin
            next_dlyAddr = curAddr + 15'h0001;
            next_dlyRd   = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dlyAddr  <= 15'h0000;
            dlyWdata <= 24'h0;
            dlyWe    <= 1'b0;
            dlyRd    <= 1'b0;
        end else begin
            dlyAddr  <= next_dlyAddr;
            dlyWdata <= next_dlyWdata;
            dlyWe    <= next_dlyWe;
            dlyRd    <= next_dlyRd;
        end
    end

    // Access phases: the write count holds at its limit until release
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wrPh    <= 3'h0;
            rdPh    <= adp_pkg::ACCESS_CLKS;
            selPrev <= 5'h00;
        end else begin
            selPrev <= delaySelect;
            if (!wrActive) begin
                wrPh <= 3'h0;
            end else if (wrPh != adp_pkg::ACCESS_CLKS) begin
                wrPh <= wrPh + 3'h1;
            end
            if (rdStart) begin
                rdPh <= 3'h1;
            end else if (rdPh != adp_pkg::ACCESS_CLKS) begin
                rdPh <= rdPh + 3'h1;
            end
        end
    end

    // Read data lands on the bus in the fourth cycle after the select
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdLo         <= 24'h0;
            delayReadBus <= 48'h0;
        end else begin
            if (rdPh == 3'h2) begin
                rdLo <= dlyRdata;
            end
            if (rdPh == 3'h3) begin
                delayReadBus <= full ? {dlyRdata, rdLo} : {24'h0, rdLo};
            end
        end
    end

    // Pointer offsets; a clear also rewinds them
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < adp_pkg::NUM_PTRS; i++) ptrOff[i] <= 15'h0000;
        end else if (clrStart) begin
            for (int i = 0; i < adp_pkg::NUM_PTRS; i++) ptrOff[i] <= 15'h0000;
        end else if (advance && selOk) begin
            ptrOff[selIdx] <= nextOff;
        end
    end

    // Overlap is not checked here; software keeps the regions apart
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < adp_pkg::NUM_PTRS; i++) endAddr[i] <= adp_pkg::END_RST;
        end else if (regWr && selEnd) begin
            endAddr[endIdx] <= regWdata[14:0];
        end
    end

    // Clear pin is asynchronous to the DSP clock, so it is synchronised first
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clrSync  <= 2'h0;
            clrLast  <= 1'b0;
            clearing <= 1'b0;
            clrAddr  <= 15'h0000;
        end else begin
            clrSync <= {clrSync[0], memClear};
            clrLast <= clrSync[1];
            if (clrStart) begin
                clearing <= 1'b1;
                clrAddr  <= 15'h0000;
            end else if (clearing) begin
                clearing <= !clrEnd;
                clrAddr  <= clrAddr + 15'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clearBusy <= 1'b0;
        end else begin
            clearBusy <= clrStart || (clearing && !clrEnd);
        end
    end

    // Register read, zero outside the strobe's following cycle
    logic [47:0] next_rdata;

    always_comb begin
        next_rdata = 48'h0;
        if (selCoef) begin
            next_rdata = {20'h0, coefMem[memIdx]};
        end else if (selData) begin
            next_rdata = dataMem[memIdx];
        end else if (selSeed) begin
            next_rdata = {16'h0, seed};
        end else if (selPc) begin
            next_rdata = {36'h0, pc};
        end else if (selPtr) begin
            next_rdata = {37'h0, memPtr[ptrIdx]};
        end else if (selStat) begin
            next_rdata = {47'h0, clearing};
        end else if (selEnd) begin
            next_rdata = {33'h0, endAddr[endIdx]};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            regRdata <= 48'h0;
        end else begin
            regRdata <= regRd ? next_rdata : 48'h0;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    noEarlyAdv_a: assert property (advance |->
        $past(!delayWriteStrobe_n, 1) && $past(!delayWriteStrobe_n, 4))
        else $error("pointer advanced before a full write");
    wrapStart_a: assert property (advance && selOk && atEnd && !clrStart |=>
        ptrOff[$past(selIdx)] == 15'h0000)
        else $error("pointer did not wrap to region start");
    clearZero_a: assert property (clearing |=> dlyWe && dlyWdata == 24'h0)
        else $error("clear sweep wrote nonzero data");
    sampleSign_a: assert property (frameSync |=>
        sampleWord[47:39] == ($past(sampleIn[23]) ? 9'h1FF : 9'h000))
        else $error("sample sign not at bit 39");
    outTrunc_a: assert property (instrValid && p2Op[2] |=>
        outBus[$past(p2Op[4:3])] == $past(result[47:16]))
        else $error("output bus not upper result bits");
    readIssue_a: assert property (
        delaySelect != selPrev && selOk && delayWriteStrobe_n && !clearing && !advance
        |-> ##1 (dlyRd && dlyAddr == $past(curAddr)) ##3 rdPh == adp_pkg::ACCESS_CLKS)
        else $error("delay read not issued on select change");
endmodule // adp_datapath
`default_nettype wire

// ---- adp_dly_ram.sv ----
`timescale 1ns/1ps
`default_nettype none
module adp_dly_ram (
    input  wire logic        clk_sys,  // DSP clock
    input  wire logic [14:0] dlyAddr,  // Word address
    input  wire logic [23:0] dlyWdata, // Write data
    input  wire logic        dlyWe,    // Write enable
    input  wire logic        dlyRd,    // Read enable
    output logic      [23:0] dlyRdata  // Data the cycle after a read
);
    logic [23:0] mem [0:17407];
    initial dlyRdata = 24'h000000;
    // Off-read cycles show the inverse so stale data never passes as fresh
    always @(posedge clk_sys) begin
        if (dlyWe) mem[dlyAddr] <= dlyWdata;
        dlyRdata <= dlyRd ? mem[dlyAddr] : ~dlyRdata;
    end
endmodule // adp_dly_ram
`default_nettype wire

// ---- adp_mac_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface adp_mac_if;
    logic [47:0]        operand;
    logic [27:0]        coef;
    adp_pkg::adp_macop_e op;
    logic [75:0]        acc;
    modport core (output operand, output coef, output op, input acc);
    modport unit (input operand, input coef, input op, output acc);
endinterface
`default_nettype wire

// ---- adp_mac_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module adp_mac_unit (
    input  wire logic clk_sys, // DSP clock
    input  wire logic rst,     // Asynchronous reset
    adp_mac_if.unit   mac      // Operands in, accumulator out
);
    // Full signed product, 48 x 28 into 76 bits in one cycle
    wire logic signed [75:0] product = $signed(mac.operand) * $signed(mac.coef);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mac.acc <= 76'h0;
        end else begin
            case (mac.op)
                adp_pkg::MAC_MUL: mac.acc <= product;
                // No saturation: the sum wraps and later terms may bring it back
                adp_pkg::MAC_ACC: mac.acc <= mac.acc + product;
                adp_pkg::MAC_CLR: mac.acc <= 76'h0;
                default:          mac.acc <= mac.acc;
            endcase
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);

    mulLoad_a: assert property (mac.op == adp_pkg::MAC_MUL |=> mac.acc == $past(product))
        else $error("product not loaded into accumulator");
    macWrap_a: assert property (mac.op == adp_pkg::MAC_ACC |=>
        mac.acc == 76'($past(mac.acc) + $past(product)))
        else $error("accumulate did not wrap modulo 76 bits");
endmodule // adp_mac_unit
`default_nettype wire

// ---- adp_pkg.sv ----
package adp_pkg;
    // Datapath word layout
    localparam int DW       = 48;
    localparam int CW       = 28;
    localparam int AW       = 76;
    localparam int GUARD    = 8;
    localparam int NOISE    = 16;
    localparam int SIGN_BIT = 39;
    localparam int FRAC     = 23;
    // Product of a 25.23 word and a 5.23 coefficient carries 46 fraction bits
    localparam int RES_LSB  = 23;
    localparam int OUT_LSB  = 16;

    // Instruction word fields
    localparam int EXT_BIT = 54;
    localparam int P1_LSB  = 49;
    localparam int P2_LSB  = 42;
    localparam int M1_LSB  = 37;
    localparam int A1_LSB  = 27;
    localparam int M2_LSB  = 24;
    localparam int A2_LSB  = 14;
    localparam int M3_LSB  = 10;
    localparam int A3_LSB  = 0;

    // Operand sources in the second-stage field
    localparam logic [1:0] SRC_SAMPLE = 2'h1;
    localparam logic [1:0] SRC_RAND   = 2'h2;

    typedef enum logic [1:0] {MAC_NOP, MAC_MUL, MAC_ACC, MAC_CLR} adp_macop_e;

    // Internal memories
    localparam int MEM_WORDS = 2048;

    // Delay memory
    localparam int          DLY_WORDS   = 17408;
    localparam int          SHORT_PTRS  = 16;
    localparam int          NUM_PTRS    = 24;
    localparam logic [2:0]  ACCESS_CLKS = 3'h4;
    localparam logic [14:0] END_RST     = 15'h0000;

    // Register map, word addresses
    localparam logic [12:0] DATA_BASE = 13'h0800;
    localparam logic [12:0] MISC_BASE = 13'h1000;
    localparam logic [12:0] SEED_ADDR = 13'h1000;
    localparam logic [12:0] PC_ADDR   = 13'h1001;
    localparam logic [12:0] PTR_BASE  = 13'h1002;
    localparam logic [12:0] STAT_ADDR = 13'h1006;
    localparam logic [12:0] END_BASE  = 13'h1020;
    localparam logic [31:0] SEED_RST  = 32'h0000_0001;
endpackage

// ---- audio_dsp_datapath_delay_memory_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module audio_dsp_datapath_delay_memory_tb_top;
    logic clk_sys = 1'b0, rst = 1'b1, regWr = 1'b0, regRd = 1'b0, instrValid = 1'b0;
    logic frameSync = 1'b0, delayWriteStrobe_n = 1'b1, memClear = 1'b0, clearBusy, dlyWe, dlyRd;
    logic [12:0]      regAddr = 13'h0000;
    logic [47:0]      regWdata = 48'h0, delayWriteBus = 48'h0, regRdata, delayReadBus, d;
    logic [54:0]      instrWord = 55'h0;
    logic [23:0]      sampleIn = 24'h0, dlyWdata, dlyRdata, dv [5];
    logic [4:0]       delaySelect = 5'h00;
    logic [3:0][31:0] outBus;
    logic [14:0]      dlyAddr;
    logic [75:0]      acc;
    logic [27:0]      c, c2;
    int n_fail = 0, n_compared = 0, seed = 32'h1F46;
    always #10 clk_sys = ~clk_sys;
    adp_datapath #(.CLEAR_WORDS(16)) adp_datapath_inst (.clk_sys, .rst, .regAddr, .regWdata,
        .regWr, .regRd, .regRdata, .instrWord, .instrValid, .sampleIn, .frameSync, .outBus,
        .delaySelect, .delayWriteBus, .delayWriteStrobe_n, .delayReadBus, .memClear,
        .clearBusy, .dlyAddr, .dlyWdata, .dlyWe, .dlyRd, .dlyRdata);
    adp_dly_ram adp_dly_ram_inst (.clk_sys, .dlyAddr, .dlyWdata, .dlyWe, .dlyRd, .dlyRdata);
    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Gap cycle after each write so the strobe is never driven twice in one step
    task automatic wr(input logic [12:0] a, input logic [47:0] v);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        tick(1);
        regWr <= 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [12:0] a, input logic [47:0] e);
        regAddr <= a;
        regRd <= 1'b1;
        tick(1);
        regRd <= 1'b0;
        #1;
        chk("regRdata", e, regRdata);
    endtask
    task automatic ex(input logic [54:0] i);
        instrWord <= i;
        instrValid <= 1'b1;
        tick(1);
    endtask
    function automatic logic [54:0] ins(logic e, logic [4:0] p1, logic [6:0] p2,
                                        logic [9:0] a1, logic [9:0] a2);
        return {e, p1, p2, 5'h00, a1, 3'h0, a2, 4'h0, 10'h000};
    endfunction
    function automatic logic [75:0] mulx(input logic [47:0] a, input logic [27:0] k);
        return $signed({{28{a[47]}}, a}) * $signed({{48{k[27]}}, k});
    endfunction
    task automatic results();
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        tick(5);
        rst <= 1'b0;
        tick(1);
        rd(adp_pkg::SEED_ADDR, 48'(adp_pkg::SEED_RST));
        rd(13'h1FFF, 48'h0);
        // Disjoint regions of at least one sample each, written before any access
        wr(adp_pkg::END_BASE, 48'h3);
        wr(adp_pkg::END_BASE + 13'h0001, 48'h7);
        rd(adp_pkg::END_BASE, 48'h3);
        $display("Test regs done");
        for (int b = 0; b < 4; b++) begin
            d = (b == 0) ? 48'h800000000000 : 48'({$random(seed), $random(seed)});
            c = (b == 0) ? 28'h8000000 : 28'($random(seed));
            c2 = 28'($random(seed));
            wr(adp_pkg::DATA_BASE + {2'h0, b[0], 10'(b)}, d);
            wr({2'h0, b[0], 10'(b)}, {20'h0, c});
            wr({2'h0, b[0], 10'(b + 16)}, {20'h0, c2});
            ex(ins(b[0], 5'h01, 7'h00, 10'(b), 10'(b)));
            ex(ins(b[0], 5'h02, 7'h00, 10'(b), 10'(b + 16)));
            ex(ins(1'b0, 5'h00, {2'h0, 2'(b), 3'h4}, 10'h0, 10'h0));
            instrValid <= 1'b0;
            tick(1);
            #1;
            acc = mulx(d, c) + mulx(d, c2);
            chk("outBus", 48'(acc[70:39]), 48'(outBus[b]));
        end
        $display("Test mac done");
        sampleIn <= 24'($random(seed)) | 24'h800000;
        frameSync <= 1'b1;
        tick(1);
        frameSync <= 1'b0;
        wr(13'h03FF, 48'h000000800000);
        ex(ins(1'b0, 5'h01, 7'h01, 10'h0, 10'h3FF));
        ex(ins(1'b0, 5'h00, 7'h04, 10'h0, 10'h0));
        instrValid <= 1'b0;
        tick(1);
        #1;
        chk("sample", 48'({{8{sampleIn[23]}}, sampleIn}), 48'(outBus[0]));
        $display("Test sample done");
        for (int k = 0; k < 5; k++) begin
            dv[k] = 24'($random(seed));
            delayWriteBus <= {24'h0, dv[k]};
            delayWriteStrobe_n <= 1'b0;
            tick(4);
            delayWriteStrobe_n <= 1'b1;
            tick(2);
        end
        for (int k = 1; k < 5; k++)
            chk("dlyRam", 48'(dv[k]), 48'(adp_dly_ram_inst.mem[k % 4]));
        delaySelect <= 5'h01;
        tick(6);
        delaySelect <= 5'h00;
        tick(4);
        #1;
        chk("delayRead", 48'(dv[1]), delayReadBus);
        memClear <= 1'b1;
        tick(4);
        #1;
        chk("clearBusy", 48'h1, 48'(clearBusy));
        // Sample off the edge so the falling flag is never raced
        for (int i = 0; clearBusy !== 1'b0; i++) begin
            if (i == 100) begin
                n_fail++;
                results();
            end
            tick(1);
            #1;
        end
        // The last swept word reaches the store one edge after the busy flag falls
        tick(2);
        memClear <= 1'b0;
        for (int k = 0; k < 16; k++)
            chk("cleared", 48'h0, 48'(adp_dly_ram_inst.mem[k]));
        $display("Test delay done");
        results();
    end
endmodule // audio_dsp_datapath_delay_memory_tb_top
`default_nettype wire
